// ===== ougis_top.sv
// Purpose: global pending flags and source locators for eight channels
// Assumes: host reads are one-cycle strobes with a stable address
// Notes: reads of channel status registers are snooped to clear causes
`timescale 1ns/1ps
`default_nettype none
`include "ougis_regs.svh"
module ougis_top #(
    parameter int NUM_CH = `OUGIS_NUM_CH,
    parameter int CODE_W = `OUGIS_CODE_W
) (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    // host read port
    input  wire logic [7:0]                        bus_addr,
    input  wire logic                              bus_rd,
    output logic      [7:0]                        rd_data,
    output logic                                   rd_valid,
    // channel causes
    input  wire ougis_pkg::ougis_chan_src_s [7:0]  ch_src,
    // timer
    input  wire logic                              timer_timeout,
    input  wire logic                              timer_irq_en,
    // sleep
    input  wire logic [7:0]                        sleep_enable,
    input  wire logic [7:0]                        ch_asleep,
    // status views
    output logic      [7:0]                        pending_flags,
    output logic      [23:0]                       source_locator,
    output logic                                   irq_out
);
    import ougis_pkg::*;

    // register layout is fixed at eight channels of three bits
    if (NUM_CH != 8) begin : g_bad_ch
        $error("ougis_top: NUM_CH must be 8");
    end
    if (CODE_W != 3) begin : g_bad_code
        $error("ougis_top: CODE_W must be 3");
    end

    // snooped read strobes
    logic              rd_chan_space;
    logic [2:0]        rd_chan;
    logic [3:0]        rd_ofs;
    logic [7:0]        rd_status;
    logic [7:0]        rd_line;
    logic [7:0]        rd_modem;
    logic              rd_tmr_cmd;

    // held causes
    logic [7:0]        line_reg;
    logic [7:0]        tx_reg;
    logic [7:0]        modem_reg;
    logic [7:0]        special_reg;
    logic              timer_reg;
    logic              wake_reg;
    logic              all_asleep_reg;
    logic              all_asleep;
    logic              wake_evt;

    // encoder results
    ougis_cause_s [7:0] cause;
    ougis_code_t  [7:0] code;
    logic [7:0]         pend;
    logic [23:0]        src_next;
    logic [7:0]         rd_next;

    assign rd_chan_space = bus_rd && !bus_addr[`OUGIS_DEV_SPACE_BIT];
    assign rd_chan       = bus_addr[6:4];
    assign rd_ofs        = bus_addr[3:0];
    assign rd_tmr_cmd    = bus_rd && (bus_addr == `OUGIS_ADDR_TMR_CMD);

    genvar n;
    generate
        for (n = 0; n < 8; n++) begin : g_ch
            logic sel;
            logic line_set;

            assign sel = rd_chan_space && (rd_chan == 3'(n));
            assign rd_status[n] = sel && (rd_ofs == `OUGIS_OFS_STATUS);
            assign rd_line[n]   = sel && (rd_ofs == `OUGIS_OFS_LINE);
            assign rd_modem[n]  = sel && (rd_ofs == `OUGIS_OFS_MODEM);

            // line status is the OR of four error bits
            assign line_set = |ch_src[n].line_err;

            // set beats a clear in the same cycle so no event is lost
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    line_reg[n] <= 1'b0;
                else if (line_set)
                    line_reg[n] <= 1'b1;
                else if (rd_line[n])
                    line_reg[n] <= 1'b0;
            end

            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    tx_reg[n] <= 1'b0;
                else if (ch_src[n].tx_ready_evt)
                    tx_reg[n] <= 1'b1;
                else if (rd_status[n])
                    tx_reg[n] <= 1'b0;
            end

            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    modem_reg[n] <= 1'b0;
                else if (ch_src[n].modem_evt)
                    modem_reg[n] <= 1'b1;
                else if (rd_modem[n])
                    modem_reg[n] <= 1'b0;
            end

            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    special_reg[n] <= 1'b0;
                else if (ch_src[n].special_evt)
                    special_reg[n] <= 1'b1;
                else if (rd_status[n])
                    special_reg[n] <= 1'b0;
            end

            // fifo levels come straight in; they drop as the host drains
            assign cause[n].rx_ready   = ch_src[n].rx_ready;
            assign cause[n].rx_timeout = ch_src[n].rx_timeout;
            assign cause[n].line_err   = line_reg[n];
            assign cause[n].tx_ready   = tx_reg[n];
            assign cause[n].modem      = modem_reg[n];
            assign cause[n].special    = special_reg[n];
            // timer and wake-up only ever land on channel 0
            assign cause[n].timer      = (n == 0) ? timer_reg : 1'b0;
            assign cause[n].wake       = (n == 0) ? wake_reg : 1'b0;

            ougis_prio_enc #(
                .HAS_TIMER (n == 0)
            ) u_enc (
                .cause     (cause[n]),
                .code      (code[n]),
                .pending   (pend[n])
            );

            // channel n fills bits 3n+2 down to 3n
            assign src_next[3*n +: 3] = code[n];
        end
    endgenerate

    // timer mask is its own enable, not a channel enable
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            timer_reg <= 1'b0;
        else if (timer_timeout && timer_irq_en)
            timer_reg <= 1'b1;
        else if (rd_tmr_cmd)
            timer_reg <= 1'b0;
    end

    // wake-up arms only while every channel sleeps
    assign all_asleep = &ch_asleep;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            all_asleep_reg <= 1'b0;
        else
            all_asleep_reg <= all_asleep;
    end

    // sleep enable of all channels doubles as the wake-up mask
    assign wake_evt = all_asleep_reg && !all_asleep && (&sleep_enable);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            wake_reg <= 1'b0;
        else if (wake_evt)
            wake_reg <= 1'b1;
        else if (rd_status[0])
            wake_reg <= 1'b0;
    end

    // flags straight from causes; no global mask stage
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pending_flags <= `OUGIS_REG_RESET;
        else
            pending_flags <= pend;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            source_locator <= `OUGIS_SRC_RESET;
        else
            source_locator <= src_next;
    end

    // taken from the same next value so it tracks the flags exactly
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            irq_out <= 1'b0;
        else
            irq_out <= |pend;
    end

    // read mux over the four consecutive global registers
    always_comb
    begin
        unique case (bus_addr)
            `OUGIS_ADDR_PENDING:  rd_next = pending_flags;
            `OUGIS_ADDR_SRC_LOW:  rd_next = source_locator[7:0];
            `OUGIS_ADDR_SRC_MID:  rd_next = source_locator[15:8];
            `OUGIS_ADDR_SRC_HIGH: rd_next = source_locator[23:16];
            default:              rd_next = `OUGIS_REG_RESET;
        endcase
    end

    // other addresses belong to other blocks and get no answer here
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rd_data  <= `OUGIS_REG_RESET;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= bus_rd && (bus_addr[7:2] == 6'(`OUGIS_ADDR_PENDING >> 2));
            if (bus_rd)
                rd_data <= rd_next;
        end
    end

endmodule : ougis_top
`default_nettype wire

// ===== ougis_regs.svh
// Purpose: addresses, codes and reset values of the global interrupt source block
// Assumes: byte-wide host bus, 256-byte register space
// Notes: included by the top and the priority encoder design files of the block
//
// Functional notes
// - four consecutive byte registers: flags, three locators
// - all four registers read zero after reset
// - no extra per-channel masking in global registers
// - flag bit N set while channel N pending
// - flag clears when cause-removing register read
// - three locators form 24-bit, 3-bit per channel
// - report highest-priority active source code
// - timer code 7 only in channel 0
// - timer and wake-up have own enables; the wake-up here is masked by all eight sleep enables instead
// - wake-up only after all eight channels slept
// - code 000 none or wake-up; 5,6 unused
// - code 001 rx ready or line status
// - rx ready clears when FIFO below trigger
// - code 010 rx time-out, same clearing
// - code 011 tx ready, cleared by status read
// - code 100 modem delta, cleared by modem read
// - code 100 special char, cleared by status read
// - timer time-out cleared by timer command read
// - global registers at 0x80 upward
`ifndef OUGIS_REGS_SVH
`define OUGIS_REGS_SVH

`define OUGIS_NUM_CH        8
`define OUGIS_CODE_W        3
`define OUGIS_ADDR_PENDING  8'h80
`define OUGIS_ADDR_SRC_LOW  8'h81
`define OUGIS_ADDR_SRC_MID  8'h82
`define OUGIS_ADDR_SRC_HIGH 8'h83
`define OUGIS_ADDR_TMR_CMD  8'h84
`define OUGIS_DEV_SPACE_BIT 7
`define OUGIS_OFS_STATUS    4'h2
`define OUGIS_OFS_LINE      4'h5
`define OUGIS_OFS_MODEM     4'h6
`define OUGIS_REG_RESET     8'h00
`define OUGIS_SRC_RESET     24'h000000
`define OUGIS_CODE_NONE     3'h0
`define OUGIS_CODE_RX       3'h1
`define OUGIS_CODE_RX_TMO   3'h2
`define OUGIS_CODE_TX       3'h3
`define OUGIS_CODE_MODEM    3'h4
`define OUGIS_CODE_TIMER    3'h7

`endif

// ===== ougis_pkg.sv
// Purpose: shared types of the global interrupt source block
// Assumes: ougis_regs.svh holds the numbers
// Notes: one source struct per channel
package ougis_pkg;

    // raw causes from one channel, already gated by its own enable register
    typedef struct packed {
        logic       rx_ready;
        logic       rx_timeout;
        logic [3:0] line_err;
        logic       tx_ready_evt;
        logic       modem_evt;
        logic       special_evt;
    } ougis_chan_src_s;

    // held causes seen by the priority encoder
    typedef struct packed {
        logic rx_ready;
        logic line_err;
        logic rx_timeout;
        logic tx_ready;
        logic modem;
        logic special;
        logic timer;
        logic wake;
    } ougis_cause_s;

    typedef logic [2:0] ougis_code_t;

endpackage : ougis_pkg

// ===== ougis_prio_enc.sv
// Purpose: picks one channel's reported source code and pending state
// Assumes: causes are held flags of one channel
// Notes: timer cause is honoured only where HAS_TIMER is set
`timescale 1ns/1ps
`default_nettype none
`include "ougis_regs.svh"
module ougis_prio_enc #(
    parameter bit HAS_TIMER = 1'b0
) (
    // held causes
    input  wire ougis_pkg::ougis_cause_s cause,
    // result
    output ougis_pkg::ougis_code_t       code,
    output logic                         pending
);
    import ougis_pkg::*;

    logic timer_ok;

    assign timer_ok = HAS_TIMER && cause.timer;

    always_comb
    begin
        // first match wins, highest priority first
        if (cause.rx_ready || cause.line_err)
            code = `OUGIS_CODE_RX;
        else if (cause.rx_timeout)
            code = `OUGIS_CODE_RX_TMO;
        else if (cause.tx_ready)
            code = `OUGIS_CODE_TX;
        else if (cause.modem || cause.special)
            code = `OUGIS_CODE_MODEM;
        else if (timer_ok)
            code = `OUGIS_CODE_TIMER;
        else
            code = `OUGIS_CODE_NONE;
    end

    // wake-up pends with code none
    assign pending = cause.rx_ready | cause.line_err | cause.rx_timeout
                   | cause.tx_ready | cause.modem | cause.special
                   | timer_ok | cause.wake;

endmodule : ougis_prio_enc
`default_nettype wire

// ===== ougis_top_checker.sv
// Purpose: port checks for the global interrupt source block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to ougis_top below
`timescale 1ns/1ps
`default_nettype none
module ougis_checker (
    // clock and reset
    input wire logic                             clk,
    input wire logic                             rst_n,
    // host read port
    input wire logic [7:0]                       bus_addr,
    input wire logic                             bus_rd,
    input wire logic [7:0]                       rd_data,
    input wire logic                             rd_valid,
    // causes
    input wire ougis_pkg::ougis_chan_src_s [7:0] ch_src,
    // status views
    input wire logic [7:0]                       pending_flags,
    input wire logic [23:0]                      source_locator,
    input wire logic                             irq_out
);
    import ougis_pkg::*;
    logic bad_rsv;
    logic bad_tmr;
    logic bad_idle;
    always_comb
    begin
        bad_rsv  = 1'b0;
        bad_tmr  = 1'b0;
        bad_idle = 1'b0;
        for (int n = 0; n < 8; n++)
        begin
            if (source_locator[3*n+:3] inside {3'h5, 3'h6})
                bad_rsv = 1'b1;
            if (n > 0 && source_locator[3*n+:3] == 3'h7)
                bad_tmr = 1'b1;
            if (!pending_flags[n] && source_locator[3*n+:3] != 3'h0)
                bad_idle = 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_RST: assert property (disable iff (1'b0) !rst_n |=> pending_flags == 8'h00
        && source_locator == 24'h000000 && !irq_out && !rd_valid) else $error("reset value");
    AST_IRQ_OR: assert property (irq_out == (pending_flags != 8'h00))
        else $error("irq not or of flags");
    AST_RD_FLAGS: assert property (bus_rd && bus_addr == 8'h80 |=> rd_valid
        && rd_data == $past(pending_flags)) else $error("flag read wrong");
    AST_RD_OTHER: assert property (bus_rd && !(bus_addr inside {[8'h80:8'h83]}) |=>
        !rd_valid && rd_data == 8'h00) else $error("unmapped read answered");
    AST_RX_FIRST: assert property (ch_src[2].rx_ready |=>
        source_locator[8:6] == 3'h1 && pending_flags[2]) else $error("rx not reported");
    AST_MODEM_SET: assert property (ch_src[2].modem_evt |-> ##2 pending_flags[2])
        else $error("modem event lost");
    AST_NO_RSV: assert property (!bad_rsv) else $error("reserved code");
    AST_TMR_CH0: assert property (!bad_tmr) else $error("timer code off channel 0");
    AST_IDLE_CODE: assert property (!bad_idle) else $error("code without flag");
    cover property (source_locator[2:0] == 3'h7);
    cover property (pending_flags[0] && source_locator[2:0] == 3'h0);
    cover property (source_locator[8:6] == 3'h4);
endmodule : ougis_checker
bind ougis_top ougis_checker i_chk (.clk, .rst_n, .bus_addr, .bus_rd, .rd_data, .rd_valid,
    .ch_src, .pending_flags, .source_locator, .irq_out);
`default_nettype wire

// ===== ougis_host_model.sv
// Purpose: host processor side of the register read port
// Assumes: one-cycle read strobe, answer one edge later
// Notes: idle address is inverted so a stale address never looks valid
`timescale 1ns/1ps
`default_nettype none
module ougis_host_model (
    // clock
    input  wire logic       clk,
    // read port
    output logic      [7:0] bus_addr,
    output logic            bus_rd,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid
);
    initial
    begin
        bus_addr = 8'h00;
        bus_rd   = 1'b0;
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] data, output logic valid);
        @(posedge clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd   <= 1'b0;
        bus_addr <= ~a;
        #1;
        data  = rd_data;
        valid = rd_valid;
    endtask : rd
endmodule : ougis_host_model
`default_nettype wire

// ===== tb.sv
// Purpose: directed bench for the global interrupt source block
// Assumes: host model owns the read port
// Notes: causes change by nonblocking writes at clk rise
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ougis_pkg::*;
    logic                  clk;
    logic                  rst_n;
    logic [7:0]            bus_addr;
    logic                  bus_rd;
    logic [7:0]            rd_data;
    logic                  rd_valid;
    ougis_chan_src_s [7:0] ch_src;
    logic                  tmo;
    logic                  tmo_en;
    logic [7:0]            slp_en;
    logic [7:0]            asleep;
    logic [7:0]            pending_flags;
    logic [23:0]           source_locator;
    logic                  irq_out;
    logic [7:0]            d;
    logic                  v;
    int                    errors;
    int                    total_checks;
    int                    cycles;
    ougis_top i_dut (.clk, .rst_n, .bus_addr, .bus_rd, .rd_data, .rd_valid, .ch_src,
        .timer_timeout(tmo), .timer_irq_en(tmo_en), .sleep_enable(slp_en),
        .ch_asleep(asleep), .pending_flags, .source_locator, .irq_out);
    ougis_host_model i_host (.clk, .bus_addr, .bus_rd, .rd_data, .rd_valid);
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic conclude();
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    task automatic t_reset();
        for (int a = 8'h80; a < 8'h84; a++)
        begin
            i_host.rd(a[7:0], d, v);
            chk({v, d}, 9'h100);
        end
        i_host.rd(8'h90, d, v);
        chk({v, d}, 9'h000);
    endtask : t_reset
    task automatic t_prio();
        @(posedge clk);
        ch_src[2] <= '{rx_ready: 1'b1, tx_ready_evt: 1'b1, modem_evt: 1'b1,
                       special_evt: 1'b1, default: '0};
        @(posedge clk);
        ch_src[2] <= '{rx_ready: 1'b1, default: '0};
        step(1);
        chk(source_locator, 24'h000040);
        @(posedge clk);
        ch_src[2].rx_ready <= 1'b0;
        step(1);
        chk(source_locator, 24'h0000c0);
        i_host.rd(8'h80, d, v);
        chk({irq_out, v, d}, 10'h304);
        i_host.rd(8'h22, d, v);
        step(1);
        chk(source_locator, 24'h000100);
        i_host.rd(8'h82, d, v);
        chk({v, d}, 9'h101);
        i_host.rd(8'h26, d, v);
        step(1);
        chk({irq_out, pending_flags}, 9'h000);
    endtask : t_prio
    task automatic t_line();
        @(posedge clk);
        ch_src[1].line_err <= 4'h8;
        @(posedge clk);
        ch_src[1].line_err <= 4'h0;
        step(1);
        i_host.rd(8'h81, d, v);
        chk({v, d}, 9'h108);
        // error pulse lands on the edge of the line status read: set must win
        fork
            i_host.rd(8'h15, d, v);
            begin
                @(posedge clk);
                ch_src[1].line_err <= 4'h2;
                @(posedge clk);
                ch_src[1].line_err <= 4'h0;
            end
        join
        step(1);
        chk(pending_flags, 8'h02);
        i_host.rd(8'h15, d, v);
        step(1);
        chk({irq_out, pending_flags}, 9'h000);
    endtask : t_line
    task automatic t_timer();
        @(posedge clk);
        tmo <= 1'b1;
        @(posedge clk);
        tmo <= 1'b0;
        step(1);
        chk(pending_flags, 8'h00);
        @(posedge clk);
        tmo_en <= 1'b1;
        tmo <= 1'b1;
        ch_src[5].rx_timeout <= 1'b1;
        @(posedge clk);
        tmo <= 1'b0;
        step(1);
        chk(source_locator, 24'h010007);
        chk(pending_flags, 8'h21);
        i_host.rd(8'h83, d, v);
        chk({v, d}, 9'h101);
        i_host.rd(8'h81, d, v);
        chk({v, d}, 9'h107);
        @(posedge clk);
        ch_src[5].rx_timeout <= 1'b0;
        i_host.rd(8'h84, d, v);
        step(1);
        chk(source_locator, 24'h000000);
    endtask : t_timer
    task automatic t_wake();
        // one channel not allowed to sleep: leaving sleep stays silent
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            slp_en <= (k == 0) ? 8'hfe : 8'hff;
            asleep <= 8'hff;
            @(posedge clk);
            asleep <= 8'h7f;
            step(2);
            chk(pending_flags, (k == 0) ? 8'h00 : 8'h01);
            chk(source_locator, 24'h000000);
        end
        i_host.rd(8'h02, d, v);
        step(1);
        chk(pending_flags, 8'h00);
    endtask : t_wake
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            conclude();
        end
    end
    initial
    begin
        rst_n  = 1'b0;
        ch_src = '0;
        tmo    = 1'b0;
        tmo_en = 1'b0;
        slp_en = 8'h00;
        asleep = 8'h00;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_prio();
        t_line();
        t_timer();
        t_wake();
        conclude();
    end
endmodule : tb
`default_nettype wire
